// file: bench/port_statistics_asserts.sv
// checker for the port statistics register window
module port_statistics_asserts
  import port_statistics_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
)
(
  input wire logic                  ref_clk_i,
  input wire logic                  rst_n_i,
  input wire reg_req_t              reg_req_i,
  input wire logic [7:0]            reg_rdata_o,
  input wire port_evt_t [PORTS-1:0] port_evt_i,
  input wire logic [NUM_DROP-1:0]   drop_evt_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // shadow of select, trigger, capture age
  // ****************************************
  logic [7:0] sel_q;
  logic [7:0] trig_q;
  logic [7:0] cap_sel;
  logic [7:0] cap_trig;
  logic [1:0] age;
  logic       wr_trig;
  logic       rd_data;
  logic       rd_b3;
  assign wr_trig = reg_req_i.wr && reg_req_i.addr == OFS_ADDR_TRIG;
  assign rd_data = reg_req_i.rd && reg_req_i.addr[7:2] == 6'h20;
  assign rd_b3   = reg_req_i.rd && reg_req_i.addr == OFS_DATA_B3;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_q    <= SEL_RESET;
      trig_q   <= TRIG_RESET;
      cap_sel  <= SEL_RESET;
      cap_trig <= TRIG_RESET;
      age      <= 2'h0;
    end else begin
      if (reg_req_i.wr && reg_req_i.addr == OFS_TABLE_SEL) begin
        sel_q <= reg_req_i.wdata;
      end
      if (wr_trig) begin
        trig_q <= reg_req_i.wdata;
      end
      if (wr_trig && sel_q[SEL_RD_BIT:SEL_TBL_LO] == 3'h7) begin
        cap_sel  <= sel_q;
        cap_trig <= reg_req_i.wdata;
        age      <= 2'h1;
      end else if (reg_req_i.wr && reg_req_i.addr[7:2] == 6'h20) begin
        age <= 2'h0;
      end else if (age == 2'h1) begin
        age <= 2'h2;
      end
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_idle_zero;
    !reg_req_i.rd |=> reg_rdata_o == 8'h00;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("data not zero");
  property p_sel_back;
    reg_req_i.rd && reg_req_i.addr == OFS_TABLE_SEL |=> reg_rdata_o == $past(sel_q);
  endproperty
  a_sel_back: assert property (p_sel_back) else $error("select readback");
  property p_trig_back;
    reg_req_i.rd && reg_req_i.addr == OFS_ADDR_TRIG |=> reg_rdata_o == $past(trig_q);
  endproperty
  a_trig_back: assert property (p_trig_back) else $error("trigger readback");
  property p_early;
    rd_b3 && age == 2'h1 |=> !reg_rdata_o[VALID_BIT-24];
  endproperty
  a_early: assert property (p_early) else $error("valid too early");
  property p_valid;
    rd_b3 && age == 2'h2 && !cap_sel[SEL_A8_BIT] && cap_trig < PORT_AREA_END |=> reg_rdata_o[VALID_BIT-24];
  endproperty
  a_valid: assert property (p_valid) else $error("valid missing");
  property p_port_gap;
    rd_data && age == 2'h2 && !cap_sel[SEL_A8_BIT] && cap_trig >= PORT_AREA_END |=> reg_rdata_o == 8'h00;
  endproperty
  a_port_gap: assert property (p_port_gap) else $error("unmapped port data");
  property p_drop_hi;
    rd_data && !reg_req_i.addr[1] && age == 2'h2 && cap_sel[SEL_A8_BIT] |=> reg_rdata_o == 8'h00;
  endproperty
  a_drop_hi: assert property (p_drop_hi) else $error("drop upper bytes");
  property p_drop_gap;
    rd_data && age == 2'h2 && cap_sel[SEL_A8_BIT] && cap_trig >= DROP_AREA_END |=> reg_rdata_o == 8'h00;
  endproperty
  a_drop_gap: assert property (p_drop_gap) else $error("unmapped drop data");
endmodule : port_statistics_asserts

bind port_statistics port_statistics_asserts #(.PORTS(PORTS)) u_chk (
  .ref_clk_i   (ref_clk_i),
  .rst_n_i     (rst_n_i),
  .reg_req_i   (reg_req_i),
  .reg_rdata_o (reg_rdata_o),
  .port_evt_i  (port_evt_i),
  .drop_evt_i  (drop_evt_i)
);

// file: bench/stats_host.sv
// host model reading counters through the register window
module stats_host
  import port_statistics_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  output reg_req_t        reg_req_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int gap = 0;
  initial reg_req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk_i);
    reg_req_o <= '0;
    @(posedge ref_clk_i);
    d = reg_rdata_i;
  endtask : rd
  task automatic read_word(input logic [7:0] sel, input logic [7:0] a, output logic [31:0] w);
    int n;
    wr(OFS_TABLE_SEL, sel);
    wr(OFS_ADDR_TRIG, a);
    rd(OFS_DATA_B3, w[31:24]);
    repeat (gap) @(posedge ref_clk_i);
    n = 0;
    while (!sel[SEL_A8_BIT] && !w[VALID_BIT] && n < 4) begin
      rd(OFS_DATA_B3, w[31:24]);
      n++;
    end
    rd(OFS_DATA_B2, w[23:16]);
    rd(OFS_DATA_B1, w[15:8]);
    rd(OFS_DATA_B0, w[7:0]);
  endtask : read_word
endmodule : stats_host

// file: bench/tb_port_statistics.sv
// self-checking bench for the port statistics counters
module tb_port_statistics
  import port_statistics_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                      ref_clk_i = 1'b0;
  logic                      rst_n_i = 1'b0;
  reg_req_t                  req;
  logic [7:0]                rdata;
  port_evt_t [NUM_PORTS-1:0] evt = '0;
  logic [NUM_DROP-1:0]       drop = '0;
  logic [31:0]               w;
  int                        bad_count = 0;
  int                        comparisons = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  port_statistics #(.PORTS(NUM_PORTS)) DUT (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .reg_req_i   (req),
    .reg_rdata_o (rdata),
    .port_evt_i  (evt),
    .drop_evt_i  (drop)
  );
  stats_host host (
    .ref_clk_i   (ref_clk_i),
    .reg_rdata_i (rdata),
    .reg_req_o   (req)
  );

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (bad_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic [29:0] expect_cnt(int p, int i);
    logic [29:0] m;
    m = 30'((i + p) % 4 + 1);
    if (i < 2) return m * 30'(64 + 100 * p);
    if (i == 20 || i == 21) return m * 30'(1000 + 300 * p);
    return m;
  endfunction : expect_cnt

  // ****************************************
  // stimulus
  // ****************************************
  task automatic hits();
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk_i);
      for (int p = 0; p < NUM_PORTS; p++) begin
        evt[p].rx_bytes <= 11'(64 + 100 * p);
        evt[p].tx_bytes <= 11'(1000 + 300 * p);
        for (int i = 0; i < CNT_PER_PORT; i++) evt[p].hit[i] <= (k <= (i + p) % 4);
      end
    end
    @(posedge ref_clk_i);
    evt <= '0;
  endtask : hits
  task automatic check_all(input bit full);
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int i = 0; i < CNT_PER_PORT; i++) begin
        host.read_word(SEL_RD_PORT, 8'(32 * p + i), w);
        check(w, {2'b01, full ? expect_cnt(p, i) : 30'h0});
      end
    end
  endtask : check_all

  initial begin
    logic [7:0] b;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    host.rd(OFS_TABLE_SEL, b);
    check({24'h0, b}, {24'h0, SEL_RESET});
    check_all(1'b0);
    hits();
    check_all(1'b1);
    host.gap = 3;
    check_all(1'b0);
    for (int k = 0; k < NUM_DROP; k++) begin
      @(posedge ref_clk_i);
      for (int j = 0; j < NUM_DROP; j++) drop[j] <= (k <= j);
    end
    @(posedge ref_clk_i);
    drop <= '0;
    for (int r = 0; r < 2; r++) begin
      for (int j = 0; j < NUM_DROP; j++) begin
        host.read_word(SEL_RD_DROP, 8'(j), w);
        check(w, 32'(j + 1));
      end
    end
    host.wr(OFS_TABLE_SEL, 8'h14);
    host.wr(OFS_ADDR_TRIG, 8'h02);
    host.rd(OFS_DATA_B0, b);
    check({24'h0, b}, 32'(NUM_DROP));
    host.rd(OFS_ADDR_TRIG, b);
    check({24'h0, b}, 32'h00000002);
    host.read_word(SEL_RD_PORT, PORT_AREA_END, w);
    check(w, 32'h0);
    host.read_word(SEL_RD_DROP, DROP_AREA_END, w);
    check(w, 32'h0);
    host.rd(8'h7B, b);
    check({24'h0, b}, 32'h0);
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge ref_clk_i);
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_port_statistics

// file: hw/port_drop_counters.sv
// six free-running dropped-packet counters, never cleared by reads
module port_drop_counters
  import port_statistics_pkg::*;
(
  input  wire logic                             ref_clk_i,
  input  wire logic                             rst_n_i,
  input  wire logic [NUM_DROP-1:0]              drop_evt_i,
  output logic      [NUM_DROP-1:0][DROP_W-1:0] cnt_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NUM_DROP-1:0][DROP_W-1:0] cnt;
  } drop_state_t;

  drop_state_t st_reg;
  drop_state_t st_next;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < NUM_DROP; i++) begin
      if (drop_evt_i[i]) begin
        // plain wrap, no flags, software tracks it
        st_next.cnt[i] = st_reg.cnt[i] + DROP_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cnt_o = st_reg.cnt;

endmodule : port_drop_counters

// file: hw/port_statistics.sv
// per-port statistics counters behind the indirect table window
//
// Notes on behaviour
// - three ports each keep counters; six shared dropped-packet counters besides.
// - per-port word: bit 31 overflow, bit 30 valid, 29..0 count; reset zero.
// - valid bit is one only when the returned count can be trusted.
// - port blocks of 32 counters at indirect bases 0x00, 0x20, 0x40.
// - index 0 and 1 add received low and high priority octets.
// - index 2 short good frames, index 3 short bad frames.
// - index 4 long good frames, index 5 long bad frames.
// - index 6 legal-size frames with a bad data symbol.
// - index 7 checksum failures, index 8 misaligned checksum failures.
// - index 9 received control frames.
// - index 10 received flow-stop frames that fully qualify.
// - indices 11 to 13 good broadcast, group and single-station receives.
// - indices 14 to 19 received frames binned by length.
// - indices 20 and 21 add transmitted low and high priority octets.
// - index 22 late collisions beyond 512 bit times.
// - index 23 sent flow-stop frames; 24 to 26 sent frame classes.
// - indices 27 to 31 half-duplex postpone and collision outcomes.
// - six 16-bit drop counters: transmit at 0x100.., receive at 0x103...
// - reading a per-port counter clears it to zero.
// - drop counters are not cleared by reads and carry no flags.
module port_statistics
  import port_statistics_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
)
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire reg_req_t              reg_req_i,
  output logic      [7:0]            reg_rdata_o,
  input  wire port_evt_t [PORTS-1:0] port_evt_i,
  input  wire logic [NUM_DROP-1:0]   drop_evt_i
);

  localparam int NCNT = PORTS * CNT_PER_PORT;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [NCNT-1:0][CNT_W-1:0] cnt;
    logic [NCNT-1:0]            ovf;
    logic [7:0]                 sel;
    logic [7:0]                 trig;
    logic [31:0]                data;
    logic                       pend;
    logic [7:0]                 rdata;
  } stat_state_t;

  stat_state_t st_reg;
  stat_state_t st_next;

  logic [NUM_DROP-1:0][DROP_W-1:0] drop_cnt;

  // ****************************************
  // dropped-packet counters
  // ****************************************
  port_drop_counters u_drop (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .drop_evt_i (drop_evt_i),
    .cnt_o      (drop_cnt)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [LEN_W-1:0] inc_amount(
    input port_evt_t  e,
    input logic [4:0] idx
  );
    logic [LEN_W-1:0] amt;
    amt = LEN_W'(1);
    case (idx)
      IX_RX_LOW_PRIO_OCTETS: begin
        amt = e.rx_bytes;
      end
      IX_RX_HIGH_PRIO_OCTETS: begin
        amt = e.rx_bytes;
      end
      IX_TX_LOW_PRIO_OCTETS: begin
        amt = e.tx_bytes;
      end
      IX_TX_HIGH_PRIO_OCTETS: begin
        amt = e.tx_bytes;
      end
      default: begin
        amt = LEN_W'(1);
      end
    endcase
    return amt;
  endfunction : inc_amount

  // one event strobe per counter; each index owns its class of frame
  function automatic logic is_frame_count(input logic [4:0] idx);
    logic r;
    r = 1'b1;
    if (idx == IX_RX_SHORT_GOOD || idx == IX_RX_SHORT_BAD) begin
      r = 1'b1;
    end else if (idx == IX_RX_LONG_GOOD || idx == IX_RX_LONG_BAD) begin
      r = 1'b1;
    end else if (idx == IX_RX_BAD_SYMBOL) begin
      r = 1'b1;
    end else if (idx == IX_RX_CHECKSUM_FAIL || idx == IX_RX_MISALIGNED) begin
      r = 1'b1;
    end else if (idx == IX_RX_CONTROL) begin
      r = 1'b1;
    end else if (idx == IX_RX_FLOW_STOP) begin
      r = 1'b1;
    end else if (idx >= IX_RX_ALL_STATION && idx <= IX_RX_SINGLE_STATION) begin
      r = 1'b1;
    end else if (idx >= IX_RX_LEN_MIN_BIN && idx <= IX_RX_LEN_TOP_BIN) begin
      r = 1'b1;
    end else if (idx == IX_TX_LATE_HITS) begin
      r = 1'b1;
    end else if (idx >= IX_TX_FLOW_STOP && idx <= IX_TX_SINGLE_STATION) begin
      r = 1'b1;
    end else if (idx >= IX_TX_POSTPONED && idx <= IX_TX_MANY_HIT) begin
      r = 1'b1;
    end else begin
      r = 1'b0;
    end
    return r;
  endfunction : is_frame_count

  function automatic logic [LEN_W-1:0] step(
    input port_evt_t  e,
    input logic [4:0] idx
  );
    logic [LEN_W-1:0] s;
    s = '0;
    if (e.hit[idx]) begin
      if (is_frame_count(idx)) begin
        s = LEN_W'(1);
      end else begin
        s = inc_amount(e, idx);
      end
    end
    return s;
  endfunction : step

  // table select names a read of the statistics table
  function automatic logic is_stats_read(input logic [7:0] sel);
    logic r;
    r = sel[SEL_RD_BIT] && sel[SEL_TBL_LO+1:SEL_TBL_LO] == SEL_TBL_STATS;
    return r;
  endfunction : is_stats_read

  // one-hot byte lane of the data window, bit 3 the flags byte
  function automatic logic [3:0] lane_hit(input logic [7:0] addr);
    logic [3:0] h;
    h = 4'h0;
    if (addr == OFS_DATA_B3) begin
      h = 4'h8;
    end else if (addr == OFS_DATA_B2) begin
      h = 4'h4;
    end else if (addr == OFS_DATA_B1) begin
      h = 4'h2;
    end else if (addr == OFS_DATA_B0) begin
      h = 4'h1;
    end else begin
      h = 4'h0;
    end
    return h;
  endfunction : lane_hit

  // per-port word: flags over the 30-bit count
  function automatic logic [31:0] port_word(
    input logic             ovf,
    input logic [CNT_W-1:0] cnt
  );
    logic [31:0] w;
    w            = '0;
    w[OVF_BIT]   = ovf;
    w[VALID_BIT] = 1'b1;
    w[CNT_W-1:0] = cnt;
    return w;
  endfunction : port_word

  // drop word: 16-bit count, no flags
  function automatic logic [31:0] drop_word(input logic [DROP_W-1:0] cnt);
    logic [31:0] w;
    w             = '0;
    w[DROP_W-1:0] = cnt;
    return w;
  endfunction : drop_word

  // count plus step, carry on top
  function automatic logic [CNT_W:0] bump(
    input logic [CNT_W-1:0] cnt,
    input logic [LEN_W-1:0] amt
  );
    logic [CNT_W:0] sum;
    sum = {1'b0, cnt} + {{(CNT_W + 1 - LEN_W){1'b0}}, amt};
    return sum;
  endfunction : bump

  // ****************************************
  // indirect address decode
  // ****************************************
  logic [8:0] ind_addr;
  logic       hit_port;
  logic       hit_drop;
  logic [6:0] port_ix;
  logic [2:0] drop_ix;
  logic       sel_stats_rd;

  always_comb begin
    ind_addr = {st_reg.sel[SEL_A8_BIT], st_reg.trig};
    hit_port = 1'b0;
    hit_drop = 1'b0;
    port_ix  = '0;
    drop_ix  = '0;
    if (!ind_addr[8] && st_reg.trig < PORT_AREA_END) begin
      hit_port = 1'b1;
      port_ix  = st_reg.trig[6:0];
    end else if (ind_addr[8] && st_reg.trig < DROP_AREA_END) begin
      hit_drop = 1'b1;
      drop_ix  = st_reg.trig[2:0];
    end else begin
      hit_port = 1'b0;
    end
    sel_stats_rd = is_stats_read(st_reg.sel);
  end

  // ****************************************
  // register window decode
  // ****************************************
  logic       wr_sel;
  logic       wr_trig;
  logic       rd_sel;
  logic       rd_trig;
  logic [3:0] wr_lane;
  logic [3:0] rd_lane;

  always_comb begin
    wr_sel  = reg_req_i.wr && reg_req_i.addr == OFS_TABLE_SEL;
    wr_trig = reg_req_i.wr && reg_req_i.addr == OFS_ADDR_TRIG;
    rd_sel  = reg_req_i.rd && reg_req_i.addr == OFS_TABLE_SEL;
    rd_trig = reg_req_i.rd && reg_req_i.addr == OFS_ADDR_TRIG;
    wr_lane = reg_req_i.wr ? lane_hit(reg_req_i.addr) : 4'h0;
    rd_lane = reg_req_i.rd ? lane_hit(reg_req_i.addr) : 4'h0;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = '0;

    // capture of the triggered entry, one cycle after the trigger write
    if (st_reg.pend) begin
      st_next.pend = 1'b0;
      if (hit_port) begin
        st_next.data              = port_word(st_reg.ovf[port_ix], st_reg.cnt[port_ix]);
        st_next.cnt[port_ix]      = '0;
        st_next.ovf[port_ix]      = 1'b0;
      end else if (hit_drop) begin
        st_next.data              = drop_word(drop_cnt[drop_ix]);
      end else begin
        st_next.data              = '0;
      end
    end

    // events after the clear, so a hit in the read cycle is kept
    for (int p = 0; p < PORTS; p++) begin
      for (int i = 0; i < CNT_PER_PORT; i++) begin
        logic [CNT_W:0] sum;
        int             k;
        sum = '0;
        k   = p * CNT_PER_PORT + i;
        if (port_evt_i[p].hit[i]) begin
          sum = bump(st_next.cnt[k], step(port_evt_i[p], 5'(i)));
          st_next.cnt[k] = sum[CNT_W-1:0];
          if (sum[CNT_W]) begin
            st_next.ovf[k] = 1'b1;
          end
        end
      end
    end

    // register writes
    if (wr_sel) begin
      st_next.sel = reg_req_i.wdata;
    end else if (wr_trig) begin
      st_next.trig = reg_req_i.wdata;
      if (sel_stats_rd) begin
        st_next.data = '0;
        st_next.pend = 1'b1;
      end
    end else if (wr_lane[3]) begin
      st_next.data[31:24] = reg_req_i.wdata;
    end else if (wr_lane[2]) begin
      st_next.data[23:16] = reg_req_i.wdata;
    end else if (wr_lane[1]) begin
      st_next.data[15:8] = reg_req_i.wdata;
    end else if (wr_lane[0]) begin
      st_next.data[7:0] = reg_req_i.wdata;
    end

    // register reads, answered on the next edge
    if (rd_sel) begin
      st_next.rdata = st_reg.sel;
    end else if (rd_trig) begin
      st_next.rdata = st_reg.trig;
    end else if (rd_lane[3]) begin
      st_next.rdata = st_reg.data[31:24];
    end else if (rd_lane[2]) begin
      st_next.rdata = st_reg.data[23:16];
    end else if (rd_lane[1]) begin
      st_next.rdata = st_reg.data[15:8];
    end else if (rd_lane[0]) begin
      st_next.rdata = st_reg.data[7:0];
    end else begin
      st_next.rdata = '0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg      <= '0;
      st_reg.sel  <= SEL_RESET;
      st_reg.trig <= TRIG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o = st_reg.rdata;

endmodule : port_statistics

// file: hw/port_statistics_pkg.sv
// constants and types shared by the port statistics counter block
package port_statistics_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_PORTS     = 3;
  localparam int CNT_PER_PORT  = 32;
  localparam int NUM_CNT       = NUM_PORTS * CNT_PER_PORT;
  localparam int CNT_W         = 30;
  localparam int NUM_DROP      = 6;
  localparam int DROP_W        = 16;
  localparam int LEN_W         = 11;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_TABLE_SEL  = 8'h79;
  localparam logic [7:0] OFS_ADDR_TRIG  = 8'h7A;
  localparam logic [7:0] OFS_DATA_B3    = 8'h80;
  localparam logic [7:0] OFS_DATA_B2    = 8'h81;
  localparam logic [7:0] OFS_DATA_B1    = 8'h82;
  localparam logic [7:0] OFS_DATA_B0    = 8'h83;

  // ****************************************
  // table select field layout and values
  // ****************************************
  localparam int         SEL_RD_BIT     = 4;
  localparam int         SEL_TBL_LO     = 2;
  localparam logic [1:0] SEL_TBL_STATS  = 2'h3;
  localparam int         SEL_A8_BIT     = 0;
  localparam logic [7:0] SEL_RD_PORT    = 8'h1C;
  localparam logic [7:0] SEL_RD_DROP    = 8'h1D;
  localparam logic [7:0] SEL_RESET      = 8'h00;
  localparam logic [7:0] TRIG_RESET     = 8'h00;

  // ****************************************
  // data word layout and indirect map
  // ****************************************
  localparam int         OVF_BIT        = 31;
  localparam int         VALID_BIT      = 30;
  localparam logic [7:0] PORT_BASE_1    = 8'h00;
  localparam logic [7:0] PORT_BASE_2    = 8'h20;
  localparam logic [7:0] PORT_BASE_3    = 8'h40;
  localparam logic [7:0] PORT_AREA_END  = 8'h60;
  localparam logic [7:0] DROP_TX_BASE   = 8'h00;
  localparam logic [7:0] DROP_RX_BASE   = 8'h03;
  localparam logic [7:0] DROP_AREA_END  = 8'h06;

  // ****************************************
  // per-port counter indices
  // ****************************************
  localparam logic [4:0] IX_RX_LOW_PRIO_OCTETS   = 5'h00;
  localparam logic [4:0] IX_RX_HIGH_PRIO_OCTETS  = 5'h01;
  localparam logic [4:0] IX_RX_SHORT_GOOD        = 5'h02;
  localparam logic [4:0] IX_RX_SHORT_BAD         = 5'h03;
  localparam logic [4:0] IX_RX_LONG_GOOD         = 5'h04;
  localparam logic [4:0] IX_RX_LONG_BAD          = 5'h05;
  localparam logic [4:0] IX_RX_BAD_SYMBOL        = 5'h06;
  localparam logic [4:0] IX_RX_CHECKSUM_FAIL     = 5'h07;
  localparam logic [4:0] IX_RX_MISALIGNED        = 5'h08;
  localparam logic [4:0] IX_RX_CONTROL           = 5'h09;
  localparam logic [4:0] IX_RX_FLOW_STOP         = 5'h0A;
  localparam logic [4:0] IX_RX_ALL_STATION       = 5'h0B;
  localparam logic [4:0] IX_RX_GROUP             = 5'h0C;
  localparam logic [4:0] IX_RX_SINGLE_STATION    = 5'h0D;
  localparam logic [4:0] IX_RX_LEN_MIN_BIN       = 5'h0E;
  localparam logic [4:0] IX_RX_LEN_TOP_BIN       = 5'h13;
  localparam logic [4:0] IX_TX_LOW_PRIO_OCTETS   = 5'h14;
  localparam logic [4:0] IX_TX_HIGH_PRIO_OCTETS  = 5'h15;
  localparam logic [4:0] IX_TX_LATE_HITS         = 5'h16;
  localparam logic [4:0] IX_TX_FLOW_STOP         = 5'h17;
  localparam logic [4:0] IX_TX_ALL_STATION       = 5'h18;
  localparam logic [4:0] IX_TX_SINGLE_STATION    = 5'h1A;
  localparam logic [4:0] IX_TX_POSTPONED         = 5'h1B;
  localparam logic [4:0] IX_TX_MANY_HIT          = 5'h1F;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [CNT_PER_PORT-1:0] hit;
    logic [LEN_W-1:0]        rx_bytes;
    logic [LEN_W-1:0]        tx_bytes;
  } port_evt_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : port_statistics_pkg
